// [shared/pfp_map.svh]
// Constants of the parallel flash programming port.
// Notes on behaviour
// - One lock bit: block table reads into code, latch access pin, refuse programming.
// - Two lock bits: level-two protection plus verify reads of code refused.
// - Three lock bits: level-three protection plus external execution forbidden.
// - With first lock bit, access pin latched at reset; latch must match live pin.
// - Code array programmed byte by byte; each write self-timed, about 50 us.
// - During a write, reading the last address returns inverted bit 7.
// - After the write true data returns; polling may start any time.
// - Ready output goes low after strobe rises, high when write finishes.
// - Without lower lock bits, code bytes are returned for verification.
// - Lock-read mode reports the three lock bits on data lines 2, 3, 4.
// - Verify read with lines 3.6, 3.7 low returns three signature bytes.
// - Address bit 14 on 3.4, bits 13-8 on 2.5-0, bits 7-0 on 1.7-0.
// - A self-timed byte write finishes within 80 us.
`ifndef PFP_MAP_SVH
`define PFP_MAP_SVH

// ============================================================
// Timing
`define PFP_CLK_PERIOD_NS 100
`define PFP_WRITE_TIME_NS 50000
`define PFP_WRITE_MAX_NS 80000
`define PFP_WRITE_CYCLES (`PFP_WRITE_TIME_NS / `PFP_CLK_PERIOD_NS)

// ============================================================
// Mode pin patterns, ordered {p2_6, p2_7, p3_3, p3_6, p3_7}
`define PFP_PAT_WR_CODE 5'h0F
`define PFP_PAT_RD_CODE 5'h03
`define PFP_PAT_WR_LOCK1 5'h1F
`define PFP_PAT_WR_LOCK2 5'h1C
`define PFP_PAT_WR_LOCK3 5'h16
`define PFP_PAT_RD_LOCK 5'h1A
`define PFP_PAT_ERASE 5'h14
`define PFP_PAT_RD_SIG 5'h00

// ============================================================
// Data port field positions and values
`define PFP_LOCK_READ_LSB 2
`define PFP_POLL_BIT 7
`define PFP_DATA_IDLE 8'hFF
`define PFP_SIG_LOW_ADDR 8'h00
`define PFP_SIG_SEL_0 2'h0
`define PFP_SIG_SEL_1 2'h1
`define PFP_SIG_SEL_2 2'h2

// ============================================================
// Lock levels
`define PFP_LEVEL_TABLE 3'h2
`define PFP_LEVEL_VERIFY 3'h3
`define PFP_LEVEL_EXEC 3'h4

`endif

// [shared/pfp_pkg.sv]
// Types of the parallel flash programming port.
package pfp_pkg;

  // Mode pins as sampled from the port.
  typedef struct packed {
    logic p2_6;
    logic p2_7;
    logic p3_3;
    logic p3_6;
    logic p3_7;
  } pfp_mode_pins_t;

  // Programming address as carried on the ports.
  typedef struct packed {
    logic a14;
    logic [5:0] a13_8;
    logic [7:0] a7_0;
  } pfp_addr_pins_t;

  // Request to the flash array macro.
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] wdata;
    logic we;
    logic erase;
  } pfp_flash_req_t;

  typedef enum logic [3:0] {
    MD_IDLE,
    MD_WR_CODE,
    MD_RD_CODE,
    MD_WR_LOCK1,
    MD_WR_LOCK2,
    MD_WR_LOCK3,
    MD_RD_LOCK,
    MD_ERASE,
    MD_RD_SIG
  } pfp_mode_t;

  // Whole state of the core.
  typedef struct packed {
    logic strobe_prev;
    logic [2:0] lock;
    logic ea_latch;
    logic [14:0] wr_addr;
    logic [7:0] wr_data;
    logic [2:0] pend_lock;
    logic ready;
    pfp_flash_req_t flash;
    logic [7:0] dout;
    logic dout_oe;
    logic table_block;
    logic exec_block;
    logic ea_eff;
    logic ea_mismatch;
  } pfp_core_state_t;

endpackage : pfp_pkg

// [core/pfp_write_timer.sv]
// Self-timing counter for one byte or lock bit write.
`timescale 1ns/100ps
`include "pfp_map.svh"
module pfp_write_timer #(
  parameter int unsigned CYCLES = `PFP_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Control
  input wire logic i_start,
  // Status
  output logic o_busy,
  output logic o_done
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic busy;
    logic [CW-1:0] count;
  } pfp_timer_state_t;

  pfp_timer_state_t st_r;
  pfp_timer_state_t st_nxt;

  // ============================================================
  // Countdown
  always_comb begin
    st_nxt = st_r;
    if (!st_r.busy) begin
      if (i_start) begin
        st_nxt.busy = 1'b1;
        st_nxt.count = CW'(CYCLES);
      end
    end else if (st_r.count == CW'(1)) begin
      st_nxt.busy = 1'b0;
      st_nxt.count = '0;
    end else begin
      st_nxt.count = st_r.count - CW'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '0;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign o_busy = st_r.busy;
  assign o_done = st_r.busy && (st_r.count == CW'(1));

endmodule : pfp_write_timer

// [core/pfp_prog_port.sv]
// Parallel programming and verification port of the on-chip code flash.
`timescale 1ns/100ps
`include "pfp_map.svh"
module pfp_prog_port
  import pfp_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `PFP_WRITE_CYCLES,
  parameter logic [7:0] SIG_BYTE_0 = 8'hA5, // Arbitrary value.
  parameter logic [7:0] SIG_BYTE_1 = 8'h5A, // Arbitrary value.
  parameter logic [7:0] SIG_BYTE_2 = 8'hC3  // Arbitrary value.
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_CLK_EN,

  // Device reset pin and program memory control
  input wire logic I_RST_PIN,
  input wire logic I_CODE_FETCH_STROBE_PIN_N,
  input wire logic I_ADDRESS_LATCH_WRITE_STROBE_PIN_N,
  input wire logic I_EXTERNAL_ACCESS_PROGRAM_VOLTAGE_PIN_N,
  input wire logic I_PROGRAM_VOLTAGE_HIGH,

  // Mode, address and data pins
  input wire pfp_mode_pins_t I_MODE_PINS,
  input wire pfp_addr_pins_t I_ADDR_PINS,
  input wire logic [7:0] I_DATA,
  output logic [7:0] O_DATA,
  output logic O_DATA_OE,

  // Progress
  output logic O_WRITE_DONE_INDICATOR,

  // Flash array macro
  output pfp_flash_req_t O_FLASH_REQ,
  input wire logic [7:0] I_FLASH_RDATA,

  // Protection state toward the core
  output logic [2:0] O_LOCK_BITS,
  output logic O_CODE_TABLE_READ_BLOCK,
  output logic O_EXTERNAL_EXEC_BLOCK,
  output logic O_EXTERNAL_ACCESS_EFFECTIVE,
  output logic O_EXTERNAL_ACCESS_MISMATCH
);

  // ============================================================
  // Helpers

  // Mode decode; any pattern outside the table means no mode.
  function automatic pfp_mode_t decode_mode(input pfp_mode_pins_t pins);
    pfp_mode_t md;
    md = MD_IDLE;
    unique case (pins)
      `PFP_PAT_WR_CODE: md = MD_WR_CODE;
      `PFP_PAT_RD_CODE: md = MD_RD_CODE;
      `PFP_PAT_WR_LOCK1: md = MD_WR_LOCK1;
      `PFP_PAT_WR_LOCK2: md = MD_WR_LOCK2;
      `PFP_PAT_WR_LOCK3: md = MD_WR_LOCK3;
      `PFP_PAT_RD_LOCK: md = MD_RD_LOCK;
      `PFP_PAT_ERASE: md = MD_ERASE;
      `PFP_PAT_RD_SIG: md = MD_RD_SIG;
      default: md = MD_IDLE;
    endcase
    return md;
  endfunction : decode_mode

  // Protection level from the three lock bits, 1 to 4.
  function automatic logic [2:0] lock_level(input logic [2:0] lk);
    logic [2:0] lv;
    lv = 3'h1;
    if (lk[0]) begin
      lv = `PFP_LEVEL_TABLE;
      if (lk[1]) begin
        lv = `PFP_LEVEL_VERIFY;
        if (lk[2]) begin
          lv = `PFP_LEVEL_EXEC;
        end
      end
    end
    return lv;
  endfunction : lock_level

  // Programming address assembled from the three port groups.
  function automatic logic [14:0] pin_addr(input pfp_addr_pins_t ap);
    return {ap.a14, ap.a13_8, ap.a7_0};
  endfunction : pin_addr

  // ============================================================
  // State

  pfp_core_state_t st_r;
  pfp_core_state_t st_nxt;

  logic timer_start;
  logic timer_busy;
  logic timer_done;

  pfp_mode_t mode;
  logic prog_active;
  logic strobe_rise;
  logic [2:0] level;
  logic [14:0] addr_now;

  // ============================================================
  // Write timer

  pfp_write_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_clk_en(I_CLK_EN),
    .i_start(timer_start),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  // ============================================================
  // Decode

  assign prog_active = I_RST_PIN && !I_CODE_FETCH_STROBE_PIN_N;
  assign mode = prog_active ? decode_mode(I_MODE_PINS) : MD_IDLE;
  assign level = lock_level(st_r.lock);
  assign addr_now = pin_addr(I_ADDR_PINS);

  // The write starts when the strobe returns high after its low pulse.
  assign strobe_rise = !st_r.strobe_prev && I_ADDRESS_LATCH_WRITE_STROBE_PIN_N;

  // ============================================================
  // Next state

  always_comb begin
    st_nxt = st_r;
    timer_start = 1'b0;
    st_nxt.strobe_prev = I_ADDRESS_LATCH_WRITE_STROBE_PIN_N;
    st_nxt.flash.we = 1'b0;
    st_nxt.flash.erase = 1'b0;

    // Access pin sampled while the reset pin is held outside programming mode.
    if (I_RST_PIN && !prog_active) begin
      st_nxt.ea_latch = I_EXTERNAL_ACCESS_PROGRAM_VOLTAGE_PIN_N;
    end

    // Strobe handling; strobes during a busy write are dropped.
    if (strobe_rise && I_PROGRAM_VOLTAGE_HIGH && !timer_busy) begin
      unique case (mode)
        MD_WR_CODE: begin
          if (level < `PFP_LEVEL_TABLE) begin
            timer_start = 1'b1;
            st_nxt.ready = 1'b0;
            st_nxt.wr_addr = addr_now;
            st_nxt.wr_data = I_DATA;
            st_nxt.pend_lock = 3'h0;
          end
        end
        MD_WR_LOCK1: begin
          timer_start = 1'b1;
          st_nxt.ready = 1'b0;
          st_nxt.pend_lock = 3'h1;
        end
        MD_WR_LOCK2: begin
          timer_start = 1'b1;
          st_nxt.ready = 1'b0;
          st_nxt.pend_lock = 3'h2;
        end
        MD_WR_LOCK3: begin
          timer_start = 1'b1;
          st_nxt.ready = 1'b0;
          st_nxt.pend_lock = 3'h4;
        end
        MD_ERASE: begin
          st_nxt.flash.erase = 1'b1;
          st_nxt.lock = 3'h0;
        end
        default: begin
          st_nxt.pend_lock = st_r.pend_lock;
        end
      endcase
    end

    // End of the self-timed write.
    if (timer_done) begin
      st_nxt.ready = 1'b1;
      if (st_r.pend_lock == 3'h0) begin
        st_nxt.flash.we = 1'b1;
        st_nxt.flash.wdata = st_r.wr_data;
      end else begin
        st_nxt.lock = st_r.lock | st_r.pend_lock;
      end
      st_nxt.pend_lock = 3'h0;
    end

    // Array address: the write address while busy, else the pins.
    if (timer_busy && !timer_done) begin
      st_nxt.flash.addr = st_r.wr_addr;
    end else if (timer_done) begin
      st_nxt.flash.addr = st_r.wr_addr;
    end else begin
      st_nxt.flash.addr = addr_now;
    end

    // Data port readback.
    st_nxt.dout = `PFP_DATA_IDLE;
    st_nxt.dout_oe = 1'b0;
    unique case (mode)
      MD_RD_CODE: begin
        if (level < `PFP_LEVEL_VERIFY) begin
          st_nxt.dout_oe = 1'b1;
          if (timer_busy && !timer_done && addr_now == st_r.wr_addr) begin
            st_nxt.dout = st_r.wr_data;
            st_nxt.dout[`PFP_POLL_BIT] = !st_r.wr_data[`PFP_POLL_BIT];
          end else if (timer_done && st_r.pend_lock == 3'h0 && addr_now == st_r.wr_addr) begin
            // True byte from the moment ready rises, before the array holds it.
            st_nxt.dout = st_r.wr_data;
          end else if (st_r.flash.we && addr_now == st_r.flash.addr) begin
            st_nxt.dout = st_r.flash.wdata;
          end else begin
            st_nxt.dout = I_FLASH_RDATA;
          end
        end
      end
      MD_RD_LOCK: begin
        st_nxt.dout = 8'h00;
        st_nxt.dout[`PFP_LOCK_READ_LSB +: 3] = st_r.lock;
        st_nxt.dout_oe = 1'b1;
      end
      MD_RD_SIG: begin
        st_nxt.dout_oe = 1'b1;
        if (I_ADDR_PINS.a7_0 == `PFP_SIG_LOW_ADDR && I_ADDR_PINS.a13_8[3:2] == 2'h0) begin
          unique case (I_ADDR_PINS.a13_8[1:0])
            `PFP_SIG_SEL_0: st_nxt.dout = SIG_BYTE_0;
            `PFP_SIG_SEL_1: st_nxt.dout = SIG_BYTE_1;
            `PFP_SIG_SEL_2: st_nxt.dout = SIG_BYTE_2;
            default: st_nxt.dout = `PFP_DATA_IDLE;
          endcase
        end
      end
      default: begin
        st_nxt.dout_oe = 1'b0;
      end
    endcase

    // Protection outputs toward the core.
    st_nxt.table_block = level >= `PFP_LEVEL_TABLE;
    st_nxt.exec_block = level >= `PFP_LEVEL_EXEC;
    st_nxt.ea_eff = st_r.lock[0] ? st_r.ea_latch : I_EXTERNAL_ACCESS_PROGRAM_VOLTAGE_PIN_N;
    st_nxt.ea_mismatch = st_r.lock[0] &&
                         (st_r.ea_latch != I_EXTERNAL_ACCESS_PROGRAM_VOLTAGE_PIN_N);
  end

  // ============================================================
  // Registers

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      st_r <= '0;
      st_r.strobe_prev <= 1'b1;
      st_r.ready <= 1'b1;
      st_r.dout <= `PFP_DATA_IDLE;
    end else if (I_CLK_EN) begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Outputs

  assign O_DATA = st_r.dout;
  assign O_DATA_OE = st_r.dout_oe;
  assign O_WRITE_DONE_INDICATOR = st_r.ready;
  assign O_FLASH_REQ = st_r.flash;
  assign O_LOCK_BITS = st_r.lock;
  assign O_CODE_TABLE_READ_BLOCK = st_r.table_block;
  assign O_EXTERNAL_EXEC_BLOCK = st_r.exec_block;
  assign O_EXTERNAL_ACCESS_EFFECTIVE = st_r.ea_eff;
  assign O_EXTERNAL_ACCESS_MISMATCH = st_r.ea_mismatch;

endmodule : pfp_prog_port

// [dv/pfp_prog_port_assertions.sv]
// Concurrent checks on the ports of the flash programming port.
`timescale 1ns/100ps
`include "pfp_map.svh"
module pfp_prog_port_assertions
  import pfp_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `PFP_WRITE_CYCLES
) (
  // Clock, reset and control pins
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_CLK_EN,
  input wire logic I_RST_PIN,
  input wire logic I_CODE_FETCH_STROBE_PIN_N,
  input wire logic I_ADDRESS_LATCH_WRITE_STROBE_PIN_N,
  input wire logic I_PROGRAM_VOLTAGE_HIGH,
  input wire pfp_mode_pins_t I_MODE_PINS,
  // Outputs watched
  input wire logic [7:0] O_DATA,
  input wire logic O_DATA_OE,
  input wire logic O_WRITE_DONE_INDICATOR,
  input wire pfp_flash_req_t O_FLASH_REQ,
  input wire logic [2:0] O_LOCK_BITS,
  input wire logic O_CODE_TABLE_READ_BLOCK,
  input wire logic O_EXTERNAL_EXEC_BLOCK
);
  logic prog, rd_code, rd_lock, rdy, stb;
  logic [15:0] low_r;
  assign prog = I_RST_PIN && !I_CODE_FETCH_STROBE_PIN_N;
  assign rd_code = prog && I_MODE_PINS == `PFP_PAT_RD_CODE;
  assign rd_lock = prog && I_MODE_PINS == `PFP_PAT_RD_LOCK;
  assign rdy = O_WRITE_DONE_INDICATOR;
  assign stb = I_ADDRESS_LATCH_WRITE_STROBE_PIN_N;
  // Counts the cycles of the current busy period.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      low_r <= 16'h0000;
    end else if (rdy) begin
      low_r <= 16'h0000;
    end else if (I_CLK_EN) begin
      low_r <= low_r + 16'h0001;
    end
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  chk_busy_start: assert property (
    prog && I_PROGRAM_VOLTAGE_HIGH && rdy && I_MODE_PINS == `PFP_PAT_WR_CODE
    && !O_LOCK_BITS[0] && $rose(stb) |=> !rdy) else $error("busy not started");
  chk_busy_len: assert property (
    $rose(rdy) |-> low_r == 16'(WRITE_CYCLES)) else $error("busy length wrong");
  chk_busy_cause: assert property (
    $fell(rdy) |-> $past(stb) && !$past(stb, 2) && $past(I_PROGRAM_VOLTAGE_HIGH))
    else $error("busy without strobe");
  chk_we_done: assert property (
    O_FLASH_REQ.we |-> $rose(rdy)) else $error("write not at end of busy");
  chk_we_locked: assert property (
    O_FLASH_REQ.we |-> !O_LOCK_BITS[0]) else $error("write while locked");
  chk_prot_level: assert property (
    $stable(O_LOCK_BITS) |-> O_CODE_TABLE_READ_BLOCK == O_LOCK_BITS[0]
    && O_EXTERNAL_EXEC_BLOCK == &O_LOCK_BITS) else $error("protection level wrong");
  chk_verify_off: assert property (
    (rd_code && O_LOCK_BITS[1:0] == 2'h3) [*2] |-> !O_DATA_OE && O_DATA == 8'hFF)
    else $error("verify not refused");
  chk_lock_read: assert property (
    (rd_lock && $stable(O_LOCK_BITS)) [*2] |-> O_DATA_OE
    && O_DATA == {3'h0, O_LOCK_BITS, 2'h0}) else $error("lock read wrong");
  cov_write: cover property ($rose(rdy));
  cov_erase: cover property (O_FLASH_REQ.erase);
  cov_lock3: cover property (&O_LOCK_BITS);
endmodule : pfp_prog_port_assertions

bind pfp_prog_port pfp_prog_port_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .I_REF_CLK, .I_RESET, .I_CLK_EN, .I_RST_PIN, .I_CODE_FETCH_STROBE_PIN_N,
  .I_ADDRESS_LATCH_WRITE_STROBE_PIN_N, .I_PROGRAM_VOLTAGE_HIGH, .I_MODE_PINS, .O_DATA,
  .O_DATA_OE, .O_WRITE_DONE_INDICATOR, .O_FLASH_REQ, .O_LOCK_BITS,
  .O_CODE_TABLE_READ_BLOCK, .O_EXTERNAL_EXEC_BLOCK);

// [dv/pfp_flash_model.sv]
// Behavioural model of the flash array behind the port.
`timescale 1ns/100ps
module pfp_flash_model
  import pfp_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Array access
  input wire pfp_flash_req_t i_req,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:32767];
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  assign o_rdata = mem[i_req.addr];
  always @(posedge i_clk) begin
    if (i_req.erase) begin
      foreach (mem[i]) mem[i] <= 8'hFF;
    end else if (i_req.we) begin
      mem[i_req.addr] <= i_req.wdata;
    end
  end
endmodule : pfp_flash_model

// [dv/test_parallel_flash_program_port.sv]
// Self-checking bench for the parallel flash programming port.
`timescale 1ns/100ps
`include "pfp_map.svh"
module test_parallel_flash_program_port
  import pfp_pkg::*;
;
  localparam logic [7:0] SIG [3] = '{8'hA5, 8'h5A, 8'hC3}; // Arbitrary values.
  localparam logic [4:0] LPAT [3] = '{`PFP_PAT_WR_LOCK1, `PFP_PAT_WR_LOCK2,
    `PFP_PAT_WR_LOCK3};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fetch_n = 1'b1;
  logic stb_n = 1'b1;
  logic ea_n = 1'b1;
  logic vpp = 1'b0;
  logic rst_pin = 1'b1;
  logic clk_en = 1'b1;
  pfp_mode_pins_t mode = `PFP_PAT_RD_CODE;
  pfp_addr_pins_t addr = 15'h0000;
  logic [7:0] din = 8'h00;
  logic [7:0] dout, rdata, d;
  logic oe, rdy, tbl, exb, mism, eff, look_d, look_s;
  logic [2:0] lock;
  logic [14:0] a;
  pfp_flash_req_t req;
  logic [8:0] qd [$];
  logic [4:0] qs [$];
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'h13A46D8D;
  always #50 clk = ~clk;
  pfp_prog_port #(.WRITE_CYCLES(16), .SIG_BYTE_0(SIG[0]), .SIG_BYTE_1(SIG[1]),
    .SIG_BYTE_2(SIG[2])) u_dut (.I_REF_CLK(clk), .I_RESET(rst), .I_CLK_EN(clk_en),
    .I_RST_PIN(rst_pin), .I_CODE_FETCH_STROBE_PIN_N(fetch_n),
    .I_ADDRESS_LATCH_WRITE_STROBE_PIN_N(stb_n), .I_EXTERNAL_ACCESS_PROGRAM_VOLTAGE_PIN_N(ea_n),
    .I_PROGRAM_VOLTAGE_HIGH(vpp), .I_MODE_PINS(mode), .I_ADDR_PINS(addr), .I_DATA(din),
    .O_DATA(dout), .O_DATA_OE(oe), .O_WRITE_DONE_INDICATOR(rdy), .O_FLASH_REQ(req),
    .I_FLASH_RDATA(rdata), .O_LOCK_BITS(lock), .O_CODE_TABLE_READ_BLOCK(tbl),
    .O_EXTERNAL_EXEC_BLOCK(exb), .O_EXTERNAL_ACCESS_EFFECTIVE(eff),
    .O_EXTERNAL_ACCESS_MISMATCH(mism));
  pfp_flash_model u_mem (.i_clk(clk), .i_req(req), .o_rdata(rdata));
  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  task automatic bad(input string what, input logic [8:0] e, input logic [8:0] g);
    err_count++;
    $display("BAD %s exp %h got %h", what, e, g);
  endtask : bad
  task automatic cmp_data(input logic [8:0] e);
    comparisons++;
    if ({oe, dout} !== e) bad("data", e, {oe, dout});
  endtask : cmp_data
  task automatic cmp_stat(input logic [4:0] e);
    comparisons++;
    if ({eff, mism, exb, tbl, rdy} !== e) bad("status", 9'(e), 9'({eff, mism, exb, tbl, rdy}));
  endtask : cmp_stat
  // Results are compared half a cycle after the driver notes them.
  always @(negedge clk) begin
    if (look_d) cmp_data(qd.pop_front());
    if (look_s) cmp_stat(qs.pop_front());
  end
  task automatic rd(input logic [4:0] m, input logic [14:0] ad, input logic [8:0] e);
    @(posedge clk);
    mode <= m;
    addr <= ad;
    repeat (3) @(posedge clk);
    qd.push_back(e);
    look_d <= 1'b1;
    @(posedge clk);
    look_d <= 1'b0;
  endtask : rd
  task automatic st(input logic [3:0] e, input logic f = 1'b1);
    repeat (2) @(posedge clk);
    qs.push_back({f, e});
    look_s <= 1'b1;
    @(posedge clk);
    look_s <= 1'b0;
  endtask : st
  task automatic stb(input logic [4:0] m, input logic [14:0] ad, input logic [7:0] dt,
      input int w);
    @(posedge clk);
    addr <= ad;
    @(posedge clk);
    din <= dt;
    @(posedge clk);
    mode <= m;
    @(posedge clk);
    vpp <= 1'b1;
    @(posedge clk);
    stb_n <= 1'b0;
    repeat (w) @(posedge clk);
    stb_n <= 1'b1;
  endtask : stb
  task automatic wait_rdy();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 25) begin
      @(negedge clk);
      n++;
    end
    if (rdy !== 1'b1) begin
      bad("ready", 9'h001, 9'(rdy));
      wrap_up();
    end
    @(posedge clk);
  endtask : wait_rdy
  initial begin
    look_d = 1'b0;
    look_s = 1'b0;
    a = 15'($random(seed));
    d = 8'($random(seed));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    fetch_n <= 1'b0;
    stb(`PFP_PAT_WR_CODE, a, d, 2);
    st(4'h0);
    rd(`PFP_PAT_RD_CODE, a, {1'b1, ~d[7], d[6:0]});
    wait_rdy();
    rd(`PFP_PAT_RD_CODE, a, {1'b1, d});
    stb(`PFP_PAT_WR_CODE, a ^ 15'h0100, ~d, 2);
    stb(`PFP_PAT_WR_CODE, a ^ 15'h0200, d, 2);
    wait_rdy();
    rd(`PFP_PAT_RD_CODE, a ^ 15'h0100, {1'b1, ~d});
    rd(`PFP_PAT_RD_CODE, a ^ 15'h0200, 9'h1FF);
    for (int i = 0; i < 3; i++) begin
      rd(`PFP_PAT_RD_SIG, {5'h00, 2'(i), 8'h00}, {1'b1, SIG[i]});
    end
    rd(`PFP_PAT_RD_SIG, 15'h0001, 9'h1FF);
    rd(`PFP_PAT_RD_SIG, 15'h0400, 9'h1FF);
    for (int i = 0; i < 3; i++) begin
      stb(LPAT[i], a, d, 1000);
      st({2'b00, i > 0, 1'b0});
      wait_rdy();
      rd(`PFP_PAT_RD_LOCK, a, {4'h8, 3'(7 >> (2 - i)), 2'h0});
      st({1'b0, i == 2, 2'b11});
      if (i == 0) begin
        stb(`PFP_PAT_WR_CODE, a ^ 15'h0300, 8'h00, 2);
        st(4'h3);
        rd(`PFP_PAT_RD_CODE, a ^ 15'h0300, 9'h1FF);
        clk_en <= 1'b0;
        ea_n <= 1'b0;
        st(4'h3);
        clk_en <= 1'b1;
        st(4'hB);
        rst_pin <= 1'b0;
        st(4'hB);
        rst_pin <= 1'b1;
        fetch_n <= 1'b1;
        st(4'h3, 1'b0);
        ea_n <= 1'b1;
        st(4'h3);
        fetch_n <= 1'b0;
      end
      if (i == 1) rd(`PFP_PAT_RD_CODE, a, 9'h0FF);
    end
    stb(`PFP_PAT_ERASE, a, d, 3);
    rd(`PFP_PAT_RD_LOCK, a, 9'h100);
    rd(`PFP_PAT_RD_CODE, a, 9'h1FF);
    wrap_up();
  end
endmodule : test_parallel_flash_program_port
